// ### pkg/bpms_pkg.sv
// Package for the ballast power management mode sequencer.
// Assumes a single 20 MHz clock and comparator results already synchronous to it.
package bpms_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ              = 20000000;
  localparam int unsigned ENABLE_DELAY_NS     = 10000;
  localparam int unsigned TIMEOUT_NS          = 100000;
  localparam int unsigned ENABLE_DELAY_CYC    =
    (ENABLE_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned TIMEOUT_CYC         =
    (TIMEOUT_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned TMR_W               = 16;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL           = 4'h0;
  localparam logic [3:0]  ADDR_STATUS         = 4'h4;
  localparam int unsigned CTRL_SAVE_TIMER_BIT = 0;
  localparam logic [31:0] CTRL_RESET          = 32'h0000_0001;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    BPMS_STARTUP,
    BPMS_SAVE,
    BPMS_OPERATING,
    BPMS_SHUTDOWN
  } bpms_mode_t;

  typedef struct packed {
    logic supply_turn_on_level;
    logic supply_save_low_level;
    logic supply_undervoltage_level;
    logic supply_ref_off_level;
    logic regulator_immediate_level;
    logic regulator_on_level;
    logic regulator_off_level;
    logic ref_enable_level;
    logic ref_latched_level;
    logic current_sense_trip;
  } bpms_cmp_t;

  typedef struct packed {
    logic low_gate_logic_in;
    logic high_gate_logic_in;
    logic low_side_logic_in;
    logic high_side_logic_in;
    logic power_factor_logic_in;
    logic heater_logic_in;
  } bpms_logic_t;

  typedef struct packed {
    logic low_side_gate_out;
    logic high_side_gate_out;
    logic power_factor_gate_out;
    logic heater_gate_out;
  } bpms_gates_t;

endpackage : bpms_pkg

// ### rtl/bpms_sequencer.sv
// Mode sequencer of the ballast power management unit with a Wishbone slave.
// Assumes comparator results and logic inputs arrive synchronous to clk_i.
//
// Behaviour
// - Start-up: only reference sink and startup source
// - Turn-on level reached: source off, enter save
// - Save idle: cycle startup source between levels
// - Save: reference low current, rest disabled
// - Save below reference-off level: back to start-up
// - Operating on high-gate fall after delay, reference ok
// - Operating: source off, high current, all enabled
// - No low-gate activity past time-out: back to save
// - Operating undervoltage or reference low: shutdown
// - Shutdown: source on, reference low, rest disabled
// - Shutdown: turn-on to save, reference-off to start-up
// - Above immediate level: bypass switch on at once
// - Between on and immediate: on at low-gate fall
// - Below off level: off at low-gate fall
// - Reference only above reference-off level, else sink
// - Enabled gates follow their logic inputs
// - Bootstrap switch on only with low-side gate
// - Overcurrent protection parallel, only while operating
// - Drivers held low during start-up
// - Overcurrent latch forces half-bridge low, flag high
// - Both half-bridge inputs high force the two half-bridge gates low
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module bpms_sequencer #(
  parameter int unsigned ENABLE_DELAY_CYC = bpms_pkg::ENABLE_DELAY_CYC,
  parameter int unsigned TIMEOUT_CYC      = bpms_pkg::TIMEOUT_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire bpms_pkg::bpms_cmp_t   cmp_i,
  input  wire bpms_pkg::bpms_logic_t logic_i,
  output bpms_pkg::bpms_gates_t      gates_o,
  output logic                       overcurrent_flag_out_o,
  output logic                       hv_startup_source_o,
  output logic                       ref_enable_o,
  output logic                       ref_high_current_o,
  output logic                       ref_sink_o,
  output logic                       regulator_enable_o,
  output logic                       supply_bypass_switch_o,
  output logic                       bootstrap_switch_o,
  output logic                       ocp_enable_o,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  bpms_pkg::bpms_mode_t          mode_r;
  bpms_pkg::bpms_mode_t          mode_nxt;
  logic [bpms_pkg::TMR_W-1:0]    save_cnt_r;
  logic [bpms_pkg::TMR_W-1:0]    idle_cnt_r;
  logic                          low_gate_d_r;
  logic                          high_gate_d_r;
  logic                          src_cycle_r;
  logic                          ref_on_r;
  logic                          ocp_latch_r;
  logic                          bypass_r;
  logic                          save_timer_en_r;
  logic [31:0]                   ctrl_r;
  logic                          low_gate_edge;
  logic                          low_gate_fall;
  logic                          high_gate_fall;
  logic                          delay_done;
  logic                          timed_out;
  logic                          operating;
  logic                          interlock;
  logic                          oc_block;

  function automatic logic [bpms_pkg::TMR_W-1:0] sat_inc(
    input logic [bpms_pkg::TMR_W-1:0] v
  );
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  // ---------------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_gate_d_r  <= 1'b0;
      high_gate_d_r <= 1'b0;
    end else if (ce_i) begin
      low_gate_d_r  <= logic_i.low_gate_logic_in;
      high_gate_d_r <= logic_i.high_gate_logic_in;
    end
  end

  assign low_gate_edge  = low_gate_d_r ^ logic_i.low_gate_logic_in;
  assign low_gate_fall  = low_gate_d_r & ~logic_i.low_gate_logic_in;
  assign high_gate_fall = high_gate_d_r & ~logic_i.high_gate_logic_in;
  assign operating = (mode_r == bpms_pkg::BPMS_OPERATING);

  // ---------------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------------
  // Counters saturate so a long stay in a mode never wraps into a false expiry.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      save_cnt_r <= '0;
    end else if (ce_i) begin
      if (mode_r != bpms_pkg::BPMS_SAVE || mode_nxt != bpms_pkg::BPMS_SAVE) begin
        save_cnt_r <= '0;
      end else begin
        save_cnt_r <= sat_inc(save_cnt_r);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_r <= '0;
    end else if (ce_i) begin
      if (!operating || low_gate_edge) begin
        idle_cnt_r <= '0;
      end else begin
        idle_cnt_r <= sat_inc(idle_cnt_r);
      end
    end
  end

  assign delay_done = !save_timer_en_r ||
                      (32'(save_cnt_r) >= ENABLE_DELAY_CYC - 1);
  assign timed_out  = 32'(idle_cnt_r) >= TIMEOUT_CYC;

  // ---------------------------------------------------------------------------
  // Mode machine
  // ---------------------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      bpms_pkg::BPMS_STARTUP: begin
        if (cmp_i.supply_turn_on_level) begin
          mode_nxt = bpms_pkg::BPMS_SAVE;
        end
      end
      bpms_pkg::BPMS_SAVE: begin
        if (!cmp_i.supply_ref_off_level) begin
          mode_nxt = bpms_pkg::BPMS_STARTUP;
        end else if (high_gate_fall && delay_done && cmp_i.ref_enable_level) begin
          mode_nxt = bpms_pkg::BPMS_OPERATING;
        end
      end
      bpms_pkg::BPMS_OPERATING: begin
        if (!cmp_i.supply_undervoltage_level || !cmp_i.ref_latched_level) begin
          mode_nxt = bpms_pkg::BPMS_SHUTDOWN;
        end else if (timed_out) begin
          mode_nxt = bpms_pkg::BPMS_SAVE;
        end
      end
      bpms_pkg::BPMS_SHUTDOWN: begin
        if (cmp_i.supply_turn_on_level) begin
          mode_nxt = bpms_pkg::BPMS_SAVE;
        end else if (!cmp_i.supply_ref_off_level) begin
          mode_nxt = bpms_pkg::BPMS_STARTUP;
        end
      end
      default: mode_nxt = bpms_pkg::BPMS_STARTUP;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= bpms_pkg::BPMS_STARTUP;
    end else if (ce_i) begin
      mode_r <= mode_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Startup source cycling in save mode
  // ---------------------------------------------------------------------------
  // Hysteresis: on at the save low level, off again at the turn-on level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_cycle_r <= 1'b0;
    end else if (ce_i) begin
      if (mode_r != bpms_pkg::BPMS_SAVE || low_gate_edge) begin
        src_cycle_r <= 1'b0;
      end else if (cmp_i.supply_turn_on_level) begin
        src_cycle_r <= 1'b0;
      end else if (!cmp_i.supply_save_low_level) begin
        src_cycle_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Reference output
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_on_r <= 1'b0;
    end else if (ce_i) begin
      if (!cmp_i.supply_ref_off_level || mode_nxt == bpms_pkg::BPMS_STARTUP) begin
        ref_on_r <= 1'b0;
      end else if (mode_nxt != bpms_pkg::BPMS_STARTUP) begin
        ref_on_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Supply bypass switch
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bypass_r <= 1'b0;
    end else if (ce_i) begin
      if (!operating) begin
        bypass_r <= 1'b0;
      end else if (cmp_i.regulator_immediate_level) begin
        bypass_r <= 1'b1;
      end else if (low_gate_fall && cmp_i.regulator_on_level) begin
        bypass_r <= 1'b1;
      end else if (low_gate_fall && !cmp_i.regulator_off_level) begin
        bypass_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Overcurrent latch
  // ---------------------------------------------------------------------------
  // The trip wins over the release in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ocp_latch_r <= 1'b0;
    end else if (ce_i) begin
      if (!operating) begin
        ocp_latch_r <= 1'b0;
      end else if (cmp_i.current_sense_trip) begin
        ocp_latch_r <= 1'b1;
      end else if (!logic_i.low_side_logic_in && !logic_i.high_side_logic_in) begin
        ocp_latch_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign interlock = logic_i.low_side_logic_in & logic_i.high_side_logic_in;
  // A fresh trip blocks the half-bridge at once, not one cycle after the latch.
  assign oc_block  = ocp_latch_r | (operating & cmp_i.current_sense_trip);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gates_o <= '0;
    end else if (ce_i) begin
      if (mode_nxt != bpms_pkg::BPMS_OPERATING) begin
        gates_o <= '0;
      end else begin
        gates_o.low_side_gate_out     <= logic_i.low_side_logic_in &
                                         ~interlock & ~oc_block;
        gates_o.high_side_gate_out    <= logic_i.high_side_logic_in &
                                         ~interlock & ~oc_block;
        gates_o.power_factor_gate_out <= logic_i.power_factor_logic_in;
        gates_o.heater_gate_out       <= logic_i.heater_logic_in;
      end
    end
  end

  assign bootstrap_switch_o     = gates_o.low_side_gate_out;
  assign overcurrent_flag_out_o = ocp_latch_r;
  assign hv_startup_source_o    = (mode_r == bpms_pkg::BPMS_STARTUP) ||
                                  (mode_r == bpms_pkg::BPMS_SHUTDOWN) ||
                                  src_cycle_r;
  assign ref_enable_o           = ref_on_r;
  assign ref_sink_o             = ~ref_on_r;
  assign ref_high_current_o     = ref_on_r & operating;
  assign regulator_enable_o     = operating;
  assign ocp_enable_o           = operating;
  assign supply_bypass_switch_o = bypass_r & operating;

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  // Software may bypass the enable delay for bench work; reset keeps it on.
  assign save_timer_en_r = ctrl_r[bpms_pkg::CTRL_SAVE_TIMER_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= bpms_pkg::CTRL_RESET;
    end else if (ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                 wb_adr_i == bpms_pkg::ADDR_CTRL && wb_sel_i[0]) begin
      ctrl_r <= {31'h0000_0000, wb_dat_i[0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        bpms_pkg::ADDR_CTRL:   wb_dat_o <= ctrl_r;
        bpms_pkg::ADDR_STATUS: wb_dat_o <= {22'h000000, ocp_latch_r, bypass_r,
                                            ref_on_r, src_cycle_r, gates_o,
                                            mode_r};
        default:               wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : bpms_sequencer

// ### tb/bpms_mcu_model.sv
// Behavioural controller that drives the gate logic inputs of the sequencer.
// Assumes the bench clock and reset; the bench sets the other logic inputs.
`timescale 1ns/100ps
module bpms_mcu_model (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  toggle_i,
  input  wire logic                  fall_i,
  input  wire bpms_pkg::bpms_logic_t side_i,
  output bpms_pkg::bpms_logic_t      logic_o
);
  // ---------------------------------------------------------------
  // Gate activity
  // ---------------------------------------------------------------
  logic [1:0] cnt_r;
  logic       lg_r;
  logic       hg_r;

  // The low-gate line stops dead when asked, so the time-out can fire.
  always_ff @(posedge clk_i) begin
    if (rst_i || !toggle_i) begin
      cnt_r <= 2'h0;
      lg_r  <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == 2'h3) lg_r <= ~lg_r;
    end
  end

  always_ff @(posedge clk_i) begin
    hg_r <= rst_i | ~fall_i;
  end

  always_comb begin
    logic_o                    = side_i;
    logic_o.low_gate_logic_in  = lg_r;
    logic_o.high_gate_logic_in = hg_r;
  end
endmodule : bpms_mcu_model

// ### tb/bpms_seq_assertions.sv
// Port checker of the mode sequencer.
// Assumes it is bound to bpms_sequencer with its single clock.
`timescale 1ns/100ps
module bpms_seq_assertions (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  ce_i,
  input wire bpms_pkg::bpms_cmp_t   cmp_i,
  input wire bpms_pkg::bpms_logic_t logic_i,
  input wire bpms_pkg::bpms_gates_t gates_o,
  input wire logic                  overcurrent_flag_out_o,
  input wire logic                  hv_startup_source_o,
  input wire logic                  ref_enable_o,
  input wire logic                  ref_high_current_o,
  input wire logic                  ref_sink_o,
  input wire logic                  regulator_enable_o,
  input wire logic                  supply_bypass_switch_o,
  input wire logic                  bootstrap_switch_o,
  input wire logic                  ocp_enable_o,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req_s; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i; endsequence
  sequence ack_s; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence op_next_s; ce_i ##1 ocp_enable_o; endsequence

  bus_ack_a: assert property (bus_req_s |=> ack_s)
    else $error("Bus ack not one cycle.");
  reset_exit_a: assert property ($fell(rst_i) |-> gates_o == '0
    && hv_startup_source_o && ref_sink_o && !ocp_enable_o) else $error("Bad reset state.");
  boot_follow_a: assert property (bootstrap_switch_o == gates_o.low_side_gate_out)
    else $error("Bootstrap switch wrong.");
  ref_sink_a: assert property (ref_sink_o != ref_enable_o)
    else $error("Sink and reference overlap.");
  op_funcs_a: assert property (ocp_enable_o |-> regulator_enable_o && ref_enable_o
    && ref_high_current_o && !hv_startup_source_o) else $error("Operating outputs wrong.");
  gates_mode_a: assert property (gates_o != '0 |-> ocp_enable_o)
    else $error("Gate on outside operating.");
  gate_follow_a: assert property (op_next_s |-> gates_o.heater_gate_out ==
    $past(logic_i.heater_logic_in) && gates_o.power_factor_gate_out ==
    $past(logic_i.power_factor_logic_in)) else $error("Gate does not follow input.");
  cross_lock_a: assert property (ce_i && logic_i.low_side_logic_in &&
    logic_i.high_side_logic_in |=> !gates_o.low_side_gate_out && !gates_o.high_side_gate_out)
    else $error("Interlock failed.");
  oc_trip_a: assert property (ce_i && ocp_enable_o && cmp_i.current_sense_trip |=>
    !ocp_enable_o || overcurrent_flag_out_o && !gates_o.low_side_gate_out)
    else $error("Overcurrent not latched.");
  bypass_now_a: assert property (ce_i && ocp_enable_o && cmp_i.regulator_immediate_level
    |=> supply_bypass_switch_o || !ocp_enable_o) else $error("Bypass not immediate.");
  ref_off_a: assert property (ce_i && !cmp_i.supply_ref_off_level |-> ##[1:2]
    !ref_enable_o) else $error("Reference stays on.");
endmodule : bpms_seq_assertions

bind bpms_sequencer bpms_seq_assertions u_bpms_seq_assertions (.clk_i, .rst_i, .ce_i,
  .cmp_i, .logic_i, .gates_o, .overcurrent_flag_out_o, .hv_startup_source_o, .ref_enable_o,
  .ref_high_current_o, .ref_sink_o, .regulator_enable_o, .supply_bypass_switch_o,
  .bootstrap_switch_o, .ocp_enable_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ### tb/testbench.sv
// Self-checking bench of the mode sequencer with a controller model.
// Assumes short delay and time-out counts set at the instance.
`timescale 1ns/100ps
module testbench;
  // ---------------------------------------------------------------
  // Stimulus and checks
  // ---------------------------------------------------------------
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  ce = 1'b1;
  logic                  cyc, stb, we, tog, fall, ack;
  logic                  flag, src, ref_on, ref_hi, sink, reg_en, byp, boot, overcurrent_latch;
  logic [3:0]            adr;
  logic [31:0]           dat, rdat, wdo;
  bpms_pkg::bpms_cmp_t   cmp;
  bpms_pkg::bpms_logic_t side, lgc;
  bpms_pkg::bpms_gates_t gates, eg;
  int                    err_count = 0;
  int                    comparisons = 0;
  int                    seed = 30;
  int                    m;

  always #25 clk_i = ~clk_i;

  bpms_mcu_model u_bpms_mcu_model (.clk_i(clk_i), .rst_i(rst_i), .toggle_i(tog),
    .fall_i(fall), .side_i(side), .logic_o(lgc));
  bpms_sequencer #(.ENABLE_DELAY_CYC(8), .TIMEOUT_CYC(20)) u_bpms_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cmp_i(cmp), .logic_i(lgc), .gates_o(gates),
    .overcurrent_flag_out_o(flag), .hv_startup_source_o(src), .ref_enable_o(ref_on),
    .ref_high_current_o(ref_hi), .ref_sink_o(sink), .regulator_enable_o(reg_en),
    .supply_bypass_switch_o(byp), .bootstrap_switch_o(boot), .ocp_enable_o(overcurrent_latch),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1);
    rdat = wdo;
    @(posedge clk_i);
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task mode(input int e);
    wb(1'b0, 4'h4, 32'h0);
    chk(rdat[1:0], e[1:0]);
  endtask : mode

  task hg_fall;
    @(posedge clk_i) fall <= 1'b1;
    @(posedge clk_i) fall <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : hg_fall

  initial begin
    #2000000;
    err_count++;
    stop_test;
  end

  initial begin
    {cyc, stb, we, tog, fall} = '0; adr = '0; dat = '0; cmp = '0; side = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i) #1;
    chk({src, sink, ref_on, gates}, 7'h60);
    m = 0;
    mode(m);
    wb(1'b0, 4'h8, 32'h0); chk(rdat, 32'h0);
    wb(1'b0, 4'h0, 32'h0); chk(rdat, 32'h1);
    wb(1'b1, 4'h0, 32'h0);
    wb(1'b0, 4'h0, 32'h0); chk(rdat, 32'h0);
    wb(1'b1, 4'h0, 32'h1);
    wb(1'b0, 4'h0, 32'h0); chk(rdat, 32'h1);
    @(posedge clk_i);
    ce <= 1'b0;
    cmp <= '0;
    cmp.supply_ref_off_level <= 1'b1; cmp.ref_enable_level <= 1'b1;
    cmp.supply_undervoltage_level <= 1'b1; cmp.ref_latched_level <= 1'b1;
    cmp.supply_turn_on_level <= 1'b1;
    repeat (3) @(posedge clk_i); #1;
    chk({src, ref_on}, 2'h2);
    ce <= 1'b1;
    repeat (2) @(posedge clk_i); #1; m = 1;
    chk({ref_on, ref_hi, reg_en, overcurrent_latch, byp}, 5'h10);
    cmp.supply_turn_on_level <= 1'b0;
    repeat (2) @(posedge clk_i); #1;
    chk(src, 1'b1);
    cmp.supply_turn_on_level <= 1'b1;
    tog <= 1'b1;
    hg_fall;
    mode(m);
    repeat (10) @(posedge clk_i);
    hg_fall; m = 2;
    chk({src, ref_hi, reg_en, overcurrent_latch}, 4'h7);
    mode(m);
    repeat (30) begin
      @(posedge clk_i) side <= 6'($random(seed));
      @(posedge clk_i) #1;
      eg = {side.low_side_logic_in & ~side.high_side_logic_in, side.high_side_logic_in &
        ~side.low_side_logic_in, side.power_factor_logic_in, side.heater_logic_in};
      chk(gates, eg);
      chk(boot, eg.low_side_gate_out);
    end
    @(posedge clk_i) begin side <= 6'h08; cmp.current_sense_trip <= 1'b1; end
    @(posedge clk_i) cmp.current_sense_trip <= 1'b0;
    @(posedge clk_i) #1;
    chk({flag, gates.low_side_gate_out}, 2'h2);
    side <= '0;
    repeat (2) @(posedge clk_i); #1;
    chk(flag, 1'b0);
    cmp.regulator_immediate_level <= 1'b1;
    repeat (2) @(posedge clk_i); #1;
    chk(byp, 1'b1);
    cmp.regulator_immediate_level <= 1'b0;
    tog <= 1'b0;
    repeat (30) @(posedge clk_i);
    m = 1;
    mode(m);
    tog <= 1'b1;
    hg_fall; m = 2;
    mode(m);
    cmp.supply_undervoltage_level <= 1'b0; cmp.supply_turn_on_level <= 1'b0;
    repeat (2) @(posedge clk_i); #1; m = 3;
    chk({src, ref_hi, overcurrent_latch, gates}, 7'h40);
    mode(m);
    cmp.supply_ref_off_level <= 1'b0;
    repeat (3) @(posedge clk_i); #1; m = 0;
    chk({ref_on, sink}, 2'h1);
    mode(m);
    stop_test;
  end
endmodule : testbench
